// file: design/atrb_pkg.sv
// shared constants of the analog test register bank
package atrb_pkg;

    // bus widths
    localparam int ATRB_ADDR_W = 32;
    localparam int ATRB_DATA_W = 32;
    localparam int ATRB_REG_W = 8;
    localparam int ATRB_LEVEL_W = 6;
    localparam int ATRB_SAMPLE_W = 4;
    localparam int ATRB_SEL_W = 4;

    // register indices as printed; byte address is four times the index
    localparam logic [15:0] ATRB_IDX_TEST_DAC_ONE = 16'h6329;
    localparam logic [15:0] ATRB_IDX_TEST_DAC_TWO = 16'h632a;
    localparam logic [15:0] ATRB_IDX_SAMPLE_VIEW = 16'h632b;
    localparam logic [15:0] ATRB_IDX_FIELD_DET = 16'h632f;
    localparam logic [15:0] ATRB_IDX_ROUTING = 16'h6330;

    // field positions
    localparam int ATRB_LEVEL_LSB = 0;
    localparam int ATRB_SAMPLE_I_LSB = 4;
    localparam int ATRB_SAMPLE_Q_LSB = 0;
    localparam int ATRB_PD_BIT = 4;
    localparam int ATRB_SEL_ONE_LSB = 4;
    localparam int ATRB_SEL_TWO_LSB = 0;

    // reset values
    localparam logic [5:0] ATRB_LEVEL_RST = 6'h00;
    localparam logic [7:0] ATRB_FIELD_DET_RST = 8'h00;
    localparam logic [7:0] ATRB_ROUTING_RST = 8'h00;

    // aux pin source select codes
    localparam logic [3:0] ATRB_SEL_TRISTATE = 4'h0;
    localparam logic [3:0] ATRB_SEL_TEST_LEVEL = 4'h1;
    localparam logic [3:0] ATRB_SEL_SAMPLE_I = 4'h5;
    localparam logic [3:0] ATRB_SEL_SAMPLE_Q = 4'h6;
    localparam logic [3:0] ATRB_SEL_SAMPLE_IQ = 4'h7;
    localparam logic [3:0] ATRB_SEL_LOW = 4'hb;

endpackage

// file: design/atrb_register_bank.sv
// apb register bank for test levels, sample view and field detector control
//
// How it works
// - first test level six bits, upper bits zero
// - select 0001 routes first level to pin one
// - second test level six bits, upper bits zero
// - select 0001 routes second level to pin two
// - sample view: in-phase high, quadrature low
// - bit four powers down field detector
//
// register map; the byte address is four times the word index:
//   first test level, second test level, receive sample view and
//   field detector control, plus the aux pin routing word
// the routing word sits one index above the detector control;
//   its high nibble steers pin one and its low nibble pin two
//
// bus timing, no wait states:
//   setup cycle: address decoded, read word and error flag captured
//   access cycle: pready high, a write commits at its closing edge
//   read data stands on the bus until the next setup cycle
//
// output timing once a write has landed:
//   test levels and powerdown change on the next cycle
//   aux pins change one cycle later, as their source is registered
//
// aux pin select codes handled here:
//   0001 stored test level of that pin
//   0101 in-phase sample, padded with two low zeros
//   0110 quadrature sample, padded with two low zeros
//   0111 in-phase sample above the top half of quadrature
//   1011 driven low
//   any other code leaves the pin undriven, as its source lives elsewhere
//
// trade-off: registering the aux pins costs a cycle of latency but
//   keeps decode glitches off the analog test pins
//
// limitations:
//   only byte lane 0 carries data; the other lanes are ignored
//   the sample view shows the samples of the setup edge
//   a write to the sample view is taken and dropped without an error
//   unmapped addresses answer with an error and read as zero
//   test levels reset to zero; software should not rely on that
//   the routing word resets to zero, so both pins start undriven
//   detector control keeps all eight bits, reserved ones read back
module atrb_register_bank (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [atrb_pkg::ATRB_ADDR_W-1:0] i_paddr,
    input wire logic [atrb_pkg::ATRB_DATA_W-1:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic o_pready,
    output logic [atrb_pkg::ATRB_DATA_W-1:0] o_prdata,
    output logic o_pslverr,
    // receive converter samples
    input wire logic [atrb_pkg::ATRB_SAMPLE_W-1:0] i_sample_i,
    input wire logic [atrb_pkg::ATRB_SAMPLE_W-1:0] i_sample_q,
    // test converter levels
    output logic [atrb_pkg::ATRB_LEVEL_W-1:0] o_first_test_level,
    output logic [atrb_pkg::ATRB_LEVEL_W-1:0] o_second_test_level,
    // aux pins, level and drive enable
    output logic [atrb_pkg::ATRB_LEVEL_W-1:0] o_aux_out_pin_one,
    output logic o_aux_out_pin_one_oe,
    output logic [atrb_pkg::ATRB_LEVEL_W-1:0] o_aux_out_pin_two,
    output logic o_aux_out_pin_two_oe,
    // field detector
    output logic o_field_detector_powerdown
);
    import atrb_pkg::*;

    // byte address of a register index
    function automatic logic [ATRB_ADDR_W-1:0] byte_addr(input logic [15:0] idx);
        byte_addr = {14'h0000, idx, 2'b00};
    endfunction

    // decoded source for one aux pin: level and drive enable
    function automatic logic [ATRB_LEVEL_W:0] aux_source(
        input logic [ATRB_SEL_W-1:0] sel,
        input logic [ATRB_LEVEL_W-1:0] level,
        input logic [ATRB_SAMPLE_W-1:0] s_i,
        input logic [ATRB_SAMPLE_W-1:0] s_q
    );
        aux_source = {1'b0, ATRB_LEVEL_RST};
        unique case (sel)
            ATRB_SEL_TEST_LEVEL: begin
                // stored test level, all six bits
                aux_source = {1'b1, level};
            end
            ATRB_SEL_SAMPLE_I: begin
                // in-phase sample on the top four bits
                aux_source = {1'b1, s_i, 2'b00};
            end
            ATRB_SEL_SAMPLE_Q: begin
                // quadrature sample on the top four bits
                aux_source = {1'b1, s_q, 2'b00};
            end
            ATRB_SEL_SAMPLE_IQ: begin
                // in-phase above the top half of quadrature
                aux_source = {1'b1, s_i, s_q[3:2]};
            end
            ATRB_SEL_LOW: begin
                // pin driven, level zero
                aux_source = {1'b1, ATRB_LEVEL_RST};
            end
            default: begin
                // tristate and signals not present in this bank
                aux_source = {1'b0, ATRB_LEVEL_RST};
            end
        endcase
    endfunction

    // stored register state
    logic [ATRB_LEVEL_W-1:0] level_one_r;
    logic [ATRB_LEVEL_W-1:0] level_one_nxt;
    logic [ATRB_LEVEL_W-1:0] level_two_r;
    logic [ATRB_LEVEL_W-1:0] level_two_nxt;
    logic [ATRB_REG_W-1:0] field_det_r;
    logic [ATRB_REG_W-1:0] field_det_nxt;
    logic [ATRB_REG_W-1:0] routing_r;
    logic [ATRB_REG_W-1:0] routing_nxt;

    // bus answer state
    logic [ATRB_DATA_W-1:0] rdata_r;
    logic [ATRB_DATA_W-1:0] rdata_nxt;
    logic slverr_r;
    logic slverr_nxt;

    // aux output state, one entry per pin
    logic [ATRB_LEVEL_W-1:0] aux_level_r [2];
    logic [ATRB_LEVEL_W-1:0] aux_level_nxt [2];
    logic aux_oe_r [2];
    logic aux_oe_nxt [2];

    // bus phase decode
    logic setup_phase;
    logic access_phase;

    // address hits, one per register
    logic hit_one;
    logic hit_two;
    logic hit_view;
    logic hit_det;
    logic hit_route;
    logic mapped;

    // write path
    logic do_write;
    logic [ATRB_REG_W-1:0] wbyte;

    // the setup cycle decodes; the access cycle commits
    assign setup_phase = i_psel & ~i_penable;
    assign access_phase = i_psel & i_penable;
    assign hit_one = (i_paddr == byte_addr(ATRB_IDX_TEST_DAC_ONE));
    assign hit_two = (i_paddr == byte_addr(ATRB_IDX_TEST_DAC_TWO));
    assign hit_view = (i_paddr == byte_addr(ATRB_IDX_SAMPLE_VIEW));
    assign hit_det = (i_paddr == byte_addr(ATRB_IDX_FIELD_DET));
    assign hit_route = (i_paddr == byte_addr(ATRB_IDX_ROUTING));
    // the full address is compared, so aliases fall to the error answer
    assign mapped = hit_one | hit_two | hit_view | hit_det | hit_route;
    // only byte lane 0 carries data; a write without it changes nothing
    assign do_write = access_phase & i_pwrite & i_pstrb[0];
    assign wbyte = i_pwdata[ATRB_REG_W-1:0];

    // zero wait states: the access cycle always completes
    assign o_pready = access_phase;

    // next values of the writable registers
    always_comb begin
        level_one_nxt = level_one_r;
        level_two_nxt = level_two_r;
        field_det_nxt = field_det_r;
        routing_nxt = routing_r;
        if (do_write) begin
            if (hit_one) begin
                // upper two bits are read-only and dropped
                level_one_nxt = wbyte[ATRB_LEVEL_LSB +: ATRB_LEVEL_W];
            end
            if (hit_two) begin
                // same as the first level: top two bits dropped
                level_two_nxt = wbyte[ATRB_LEVEL_LSB +: ATRB_LEVEL_W];
            end
            if (hit_det) begin
                // all eight bits are stored as written; software keeps reserved ones zero
                field_det_nxt = wbyte;
            end
            if (hit_route) begin
                // both pin selects change together
                routing_nxt = wbyte;
            end
        end
    end

    // read data and error answer, captured in the setup cycle
    always_comb begin
        rdata_nxt = rdata_r;
        slverr_nxt = slverr_r;
        if (setup_phase) begin
            // clear first so writes and unmapped reads leave zero on the bus
            rdata_nxt = '0;
            slverr_nxt = ~mapped;
            if (!i_pwrite) begin
                // top two bits stay zero from the clear above
                if (hit_one) begin
                    rdata_nxt[ATRB_LEVEL_LSB +: ATRB_LEVEL_W] = level_one_r;
                end
                if (hit_two) begin
                    rdata_nxt[ATRB_LEVEL_LSB +: ATRB_LEVEL_W] = level_two_r;
                end
                if (hit_view) begin
                    // live samples; a write here is accepted and has no effect
                    rdata_nxt[ATRB_SAMPLE_I_LSB +: ATRB_SAMPLE_W] = i_sample_i;
                    rdata_nxt[ATRB_SAMPLE_Q_LSB +: ATRB_SAMPLE_W] = i_sample_q;
                end
                if (hit_det) begin
                    // reserved bits read back as stored
                    rdata_nxt[ATRB_REG_W-1:0] = field_det_r;
                end
                if (hit_route) begin
                    rdata_nxt[ATRB_REG_W-1:0] = routing_r;
                end
            end
        end
    end

    // aux pin sources, one decoder per pin
    // the sources are registered below so the pins never see decode glitches
    for (genvar p = 0; p < 2; p++) begin : g_aux
        logic [ATRB_SEL_W-1:0] sel;
        logic [ATRB_LEVEL_W-1:0] level;
        logic [ATRB_LEVEL_W:0] src;
        assign sel = (p == 0) ? routing_r[ATRB_SEL_ONE_LSB +: ATRB_SEL_W]
                              : routing_r[ATRB_SEL_TWO_LSB +: ATRB_SEL_W];
        assign level = (p == 0) ? level_one_r : level_two_r;
        // code 0001 picks the stored test level of this pin
        assign src = aux_source(sel, level, i_sample_i, i_sample_q);
        always_comb begin
            aux_level_nxt[p] = src[ATRB_LEVEL_W-1:0];
            aux_oe_nxt[p] = src[ATRB_LEVEL_W];
        end
    end

    // stored registers; the levels have no defined reset, zero is a safe pick
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            level_one_r <= ATRB_LEVEL_RST;
            level_two_r <= ATRB_LEVEL_RST;
            field_det_r <= ATRB_FIELD_DET_RST;
            routing_r <= ATRB_ROUTING_RST;
        end else begin
            level_one_r <= level_one_nxt;
            level_two_r <= level_two_nxt;
            field_det_r <= field_det_nxt;
            routing_r <= routing_nxt;
        end
    end

    // bus answer registers
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            rdata_r <= '0;
            slverr_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            slverr_r <= slverr_nxt;
        end
    end

    // aux output registers; reset leaves both pins undriven
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            for (int k = 0; k < 2; k++) begin
                aux_level_r[k] <= ATRB_LEVEL_RST;
                aux_oe_r[k] <= 1'b0;
            end
        end else begin
            for (int k = 0; k < 2; k++) begin
                aux_level_r[k] <= aux_level_nxt[k];
                aux_oe_r[k] <= aux_oe_nxt[k];
            end
        end
    end

    // bus outputs, read data straight from flip-flops
    assign o_prdata = rdata_r;
    // error only shows while the access cycle is on the bus
    assign o_pslverr = access_phase & slverr_r;

    // converter levels
    assign o_first_test_level = level_one_r;
    assign o_second_test_level = level_two_r;

    // aux pins, level and drive enable
    assign o_aux_out_pin_one = aux_level_r[0];
    assign o_aux_out_pin_one_oe = aux_oe_r[0];
    assign o_aux_out_pin_two = aux_level_r[1];
    assign o_aux_out_pin_two_oe = aux_oe_r[1];

    // field detector
    assign o_field_detector_powerdown = field_det_r[ATRB_PD_BIT];

endmodule

// file: tb/atrb_props.sv
// checker for the analog test register bank
module atrb_props (
    // clock, reset and bus
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic [31:0] o_prdata,
    // samples and outputs
    input wire logic [3:0] i_sample_i,
    input wire logic [3:0] i_sample_q,
    input wire logic [5:0] o_first_test_level,
    input wire logic [5:0] o_second_test_level,
    input wire logic [5:0] o_aux_out_pin_one,
    input wire logic o_aux_out_pin_one_oe,
    input wire logic [5:0] o_aux_out_pin_two,
    input wire logic o_aux_out_pin_two_oe,
    input wire logic o_field_detector_powerdown
);
    import atrb_pkg::*;
    logic wr;
    logic rd;
    logic [15:0] idx;
    logic [7:0] route_r;
    // decoded write and read setup; upper address bits are not decoded here
    assign wr = i_psel & i_penable & i_pwrite & i_pstrb[0];
    assign rd = i_psel & ~i_penable & ~i_pwrite;
    assign idx = i_paddr[17:2];
    // shadow of the routing register, since the pin selects are not ports
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            route_r <= 8'h00;
        end else if (wr && idx == ATRB_IDX_ROUTING) begin
            route_r <= i_pwdata[7:0];
        end
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    a_level_one_write: assert property (wr && idx == ATRB_IDX_TEST_DAC_ONE
        |=> o_first_test_level == $past(i_pwdata[5:0])) else $error("level one wrong");
    a_level_two_write: assert property (wr && idx == ATRB_IDX_TEST_DAC_TWO
        |=> o_second_test_level == $past(i_pwdata[5:0])) else $error("level two wrong");
    a_aux_one_route: assert property (route_r[7:4] == ATRB_SEL_TEST_LEVEL
        |=> o_aux_out_pin_one_oe && o_aux_out_pin_one == $past(o_first_test_level))
        else $error("aux one not routed");
    a_aux_two_route: assert property (route_r[3:0] == ATRB_SEL_TEST_LEVEL
        |=> o_aux_out_pin_two_oe && o_aux_out_pin_two == $past(o_second_test_level))
        else $error("aux two not routed");
    a_sample_read: assert property (rd && idx == ATRB_IDX_SAMPLE_VIEW
        |=> o_prdata == {24'h0, $past(i_sample_i), $past(i_sample_q)})
        else $error("sample view wrong");
    a_level_top_zero: assert property (rd && (idx == ATRB_IDX_TEST_DAC_ONE
        || idx == ATRB_IDX_TEST_DAC_TWO) |=> o_prdata[31:6] == 26'h0)
        else $error("level top bits set");
    a_pd_write: assert property (wr && idx == ATRB_IDX_FIELD_DET
        |=> o_field_detector_powerdown == $past(i_pwdata[4])) else $error("powerdown wrong");
    a_pd_hold: assert property (!(wr && idx == ATRB_IDX_FIELD_DET)
        |=> $stable(o_field_detector_powerdown)) else $error("powerdown moved");
    // main scenarios
    c_route: cover property (o_aux_out_pin_one_oe && o_aux_out_pin_two_oe);
    c_sample: cover property (rd && idx == ATRB_IDX_SAMPLE_VIEW);
    c_pd: cover property ($rose(o_field_detector_powerdown));
endmodule
bind atrb_register_bank atrb_props u_props (.*);

// file: tb/tb.sv
// self-checking bench for the analog test register bank
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import atrb_pkg::*;
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [31:0] i_paddr = 32'h0, i_pwdata = 32'h0, o_prdata;
    logic [3:0] i_pstrb = 4'hf, i_sample_i = 4'h0, i_sample_q = 4'h0;
    logic o_pready, o_pslverr, o_aux_out_pin_one_oe, o_aux_out_pin_two_oe;
    logic [5:0] o_first_test_level, o_second_test_level, o_aux_out_pin_one, o_aux_out_pin_two;
    logic o_field_detector_powerdown;
    logic [7:0] rdat;
    logic serr;
    int error_cnt = 0, total_checks = 0, cyc = 0;

    atrb_register_bank dut (.*);

    // 200 MHz clock
    initial begin
        forever #2.5 i_clock = ~i_clock;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("[ERR] %s exp %h got %h", nm, exp, got);
            error_cnt++;
        end
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] wd);
        @(posedge i_clock);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= {14'h0, idx, 2'h0};
        i_pwdata <= {24'h0, wd};
        @(posedge i_clock);
        i_penable <= 1'b1;
        do @(posedge i_clock); while (o_pready !== 1'b1);
        rdat = o_prdata[7:0];
        serr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [15:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h0);
        chk(nm, {24'h0, exp}, {24'h0, rdat});
    endtask

    // write the routing word, then look at both pins once the pipeline settles
    task automatic route_chk(input logic [7:0] code, input logic [6:0] x1, input logic [6:0] x2);
        xfer(1'b1, ATRB_IDX_ROUTING, code);
        repeat (2) @(posedge i_clock);
        chk("aux_out_pin_one_code", {25'h0, x1}, {25'h0, o_aux_out_pin_one_oe, o_aux_out_pin_one});
        chk("aux_out_pin_two_code", {25'h0, x2}, {25'h0, o_aux_out_pin_two_oe, o_aux_out_pin_two});
    endtask

    task close_out;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hang guard, far above the fewer than one hundred cycles needed
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        repeat (20) @(posedge i_clock);
        i_reset <= 1'b0;
        chk("pd_rst", 32'h0, {31'h0, o_field_detector_powerdown});
        rdchk("det_rst", ATRB_IDX_FIELD_DET, 8'h00);
        xfer(1'b1, ATRB_IDX_TEST_DAC_ONE, 8'hff);
        xfer(1'b1, ATRB_IDX_TEST_DAC_TWO, 8'hea);
        rdchk("dac1", ATRB_IDX_TEST_DAC_ONE, 8'h3f);
        rdchk("dac2", ATRB_IDX_TEST_DAC_TWO, 8'h2a);
        chk("lvl1", 32'h3f, {26'h0, o_first_test_level});
        chk("lvl2", 32'h2a, {26'h0, o_second_test_level});
        // byte strobe low: the write must be dropped
        i_pstrb <= 4'he;
        xfer(1'b1, ATRB_IDX_TEST_DAC_ONE, 8'h05);
        i_pstrb <= 4'hf;
        rdchk("dac1_keep", ATRB_IDX_TEST_DAC_ONE, 8'h3f);
        xfer(1'b1, ATRB_IDX_ROUTING, 8'h11);
        repeat (3) @(posedge i_clock);
        chk("aux_out_pin_one", 32'h7f, {25'h0, o_aux_out_pin_one_oe, o_aux_out_pin_one});
        chk("aux_out_pin_two", 32'h6a, {25'h0, o_aux_out_pin_two_oe, o_aux_out_pin_two});
        i_sample_i <= 4'ha;
        i_sample_q <= 4'h5;
        xfer(1'b1, ATRB_IDX_SAMPLE_VIEW, 8'h00);
        rdchk("adc", ATRB_IDX_SAMPLE_VIEW, 8'ha5);
        chk("no_err", 32'h0, {31'h0, serr});
        // the other decoded select codes: samples, combined, low, undriven
        route_chk(8'h56, 7'h68, 7'h54);
        route_chk(8'h7b, 7'h69, 7'h40);
        rdchk("route", ATRB_IDX_ROUTING, 8'h7b);
        route_chk(8'h00, 7'h00, 7'h00);
        xfer(1'b1, ATRB_IDX_FIELD_DET, 8'h10);
        rdchk("det", ATRB_IDX_FIELD_DET, 8'h10);
        chk("pd_on", 32'h1, {31'h0, o_field_detector_powerdown});
        xfer(1'b1, ATRB_IDX_FIELD_DET, 8'h00);
        @(posedge i_clock);
        chk("pd_off", 32'h0, {31'h0, o_field_detector_powerdown});
        xfer(1'b0, 16'h6331, 8'h00);
        chk("slverr", 32'h1, {31'h0, serr});
        chk("unmapped_rd", 32'h0, {24'h0, rdat});
        close_out();
    end
endmodule
